// ---- core/atten_pkg.sv ----
package atten_pkg;

  // ==========================================================
  // control word layout
  localparam int WORD_W = 16;
  localparam int WORD_MSB = 15;
  localparam int IDX_HI = 14;
  localparam int IDX_LO = 8;
  localparam int DATA_HI = 7;
  localparam logic WORD_MSB_VALUE = 1'b0;

  // ==========================================================
  // register indices
  localparam logic [6:0] IDX_CHAN1_GAIN = 7'h01;
  localparam logic [6:0] IDX_CHAN2_GAIN = 7'h02;
  localparam logic [6:0] IDX_CHAN3_GAIN = 7'h03;
  localparam logic [6:0] IDX_CHAN4_GAIN = 7'h04;
  localparam logic [6:0] IDX_CHAN5_GAIN = 7'h05;
  localparam logic [6:0] IDX_CHAN6_GAIN = 7'h06;
  localparam logic [6:0] IDX_SILENCE_LOW = 7'h07;
  localparam logic [6:0] IDX_DISABLE_LOW = 7'h08;
  localparam logic [6:0] IDX_FORMAT_FILTER = 7'h09;
  localparam logic [6:0] IDX_PHASE_EMPH = 7'h0a;
  localparam logic [6:0] IDX_OVERSAMPLE = 7'h0c;
  localparam logic [6:0] IDX_STEP_MODE = 7'h0d;
  localparam logic [6:0] IDX_ZERO_STATUS = 7'h0e;
  localparam logic [6:0] IDX_CHAN7_GAIN = 7'h10;
  localparam logic [6:0] IDX_CHAN8_GAIN = 7'h11;
  localparam logic [6:0] IDX_SILENCE_HIGH = 7'h12;
  localparam logic [6:0] IDX_DISABLE_HIGH = 7'h13;

  // ==========================================================
  // field positions
  localparam int LOW_CHANNELS = 6;
  localparam int HIGH_CHANNELS = 2;
  localparam int FORMAT_LO = 0;
  localparam int ROLLOFF_BIT = 5;
  localparam int EMPH_ALL_BIT = 0;
  localparam int EMPH_RATE_LO = 3;
  localparam int PHASE_INV_BIT = 5;
  localparam int ZERO_POL_BIT = 6;
  localparam int RESTART_BIT = 7;
  localparam int OVERSAMPLE_BIT = 7;
  localparam int STEP_SEL_BIT = 7;
  localparam int COMBO_LO = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0] GAIN_RESET = 8'hff;
  localparam logic [7:0] SILENCE_RESET = 8'h00;
  localparam logic [7:0] DISABLE_RESET = 8'h00;
  localparam logic [7:0] FORMAT_FILTER_RESET = 8'h05;
  localparam logic [7:0] PHASE_EMPH_RESET = 8'h00;
  localparam logic [7:0] OVERSAMPLE_RESET = 8'h00;
  localparam logic [7:0] STEP_MODE_RESET = 8'h00;

  // ==========================================================
  // attenuator figures
  localparam int NUM_CHANNELS = 8;
  localparam int GAIN_W = 8;
  localparam logic [7:0] SILENCE_FLOOR_FINE = 8'h80;
  localparam logic [7:0] SILENCE_FLOOR_WIDE = 8'h9a;
  localparam int STEP_INTERVAL_SAMPLES = 8;

endpackage

// ---- core/step_interval_timer.sv ----
`timescale 1ns/1ps
module step_interval_timer
  import atten_pkg::*;
#(
  parameter int INTERVAL = STEP_INTERVAL_SAMPLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // sample rate tick in, common step boundary out
  input wire logic i_sample_tick,
  output logic o_step
);

  localparam int CNT_W = $clog2(INTERVAL);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INTERVAL - 1);

  logic [CNT_W-1:0] cnt_reg;

  // ==========================================================
  // sample counter
  // advance per tick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (i_sample_tick) begin
      cnt_reg <= (cnt_reg == CNT_LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_step <= 1'b0;
    end else begin
      o_step <= i_sample_tick && (cnt_reg == CNT_LAST);
    end
  end

  // ==========================================================
  // checks
  step_cause_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    o_step |-> $past(i_sample_tick) && $past(cnt_reg) == CNT_LAST)
    else $error("step boundary without eighth sample tick");

endmodule

// ---- core/atten_ramp.sv ----
`timescale 1ns/1ps
module atten_ramp
  import atten_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // step boundary and target code
  input wire logic i_step,
  input wire logic [GAIN_W-1:0] i_target,
  // applied code
  output logic [GAIN_W-1:0] o_level
);

  // ==========================================================
  // ramp
  // one code per boundary
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= GAIN_RESET;
    end else if (i_step && o_level < i_target) begin
      o_level <= o_level + 1'b1;
    end else if (i_step && o_level > i_target) begin
      o_level <= o_level - 1'b1;
    end
  end

  // ==========================================================
  // checks
  hold_off_step_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_step |=> $stable(o_level))
    else $error("applied level moved off a step boundary");

  single_step_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_step && o_level != i_target |=>
      (o_level == $past(o_level) + 8'h01) ||
      (o_level == $past(o_level) - 8'h01))
    else $error("applied level did not move by one code");

endmodule

// ---- core/dac_mode_regs_attenuator.sv ----
`timescale 1ns/1ps
module dac_mode_regs_attenuator
  import atten_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // control word write
  input wire logic i_wr_valid,
  input wire logic [WORD_W-1:0] i_wr_word,
  // control word read
  input wire logic i_rd_req,
  input wire logic [6:0] i_rd_index,
  output logic o_rd_valid,
  output logic [WORD_W-1:0] o_rd_word,
  // sample timing and zero status from the data path
  input wire logic i_sample_tick,
  input wire logic [NUM_CHANNELS-1:0] i_zero_flags,
  // attenuator results
  output logic [NUM_CHANNELS*GAIN_W-1:0] o_applied_codes,
  output logic [NUM_CHANNELS-1:0] o_chan_muted,
  output logic [NUM_CHANNELS-1:0] o_chan_output_disable,
  // mode controls for other blocks
  output logic o_gain_step_select,
  output logic [2:0] o_audio_format_select,
  output logic o_rolloff_select,
  output logic o_soft_restart,
  output logic o_zero_flag_polarity,
  output logic o_output_phase_invert,
  output logic [1:0] o_emphasis_rate_select,
  output logic o_emphasis_all_enable,
  output logic o_oversample_high,
  output logic [1:0] o_zero_flag_combo_select
);

  // ==========================================================
  // functions
  // gain slot of an index: bit 3 set when the index is a gain code
  function automatic logic [3:0] gain_slot(input logic [6:0] idx);
    case (idx)
      IDX_CHAN1_GAIN: gain_slot = 4'h8;
      IDX_CHAN2_GAIN: gain_slot = 4'h9;
      IDX_CHAN3_GAIN: gain_slot = 4'ha;
      IDX_CHAN4_GAIN: gain_slot = 4'hb;
      IDX_CHAN5_GAIN: gain_slot = 4'hc;
      IDX_CHAN6_GAIN: gain_slot = 4'hd;
      IDX_CHAN7_GAIN: gain_slot = 4'he;
      IDX_CHAN8_GAIN: gain_slot = 4'hf;
      default: gain_slot = 4'h0;
    endcase
  endfunction
  function automatic logic [7:0] silence_floor(input logic wide);
    silence_floor = wide ? SILENCE_FLOOR_WIDE : SILENCE_FLOOR_FINE;
  endfunction
  // codes at or below the floor all mean silence, so clamp to it
  function automatic logic [7:0] ramp_target(input logic [7:0] code,
                                             input logic silent,
                                             input logic wide);
    logic [7:0] fl;
    fl = silence_floor(wide);
    ramp_target = (silent || code <= fl) ? fl : code;
  endfunction

  // ==========================================================
  // write decode
  // a set msb makes the word void
  wire logic wr_ok = i_wr_valid && (i_wr_word[WORD_MSB] == WORD_MSB_VALUE);
  wire logic [6:0] wr_idx = i_wr_word[IDX_HI:IDX_LO];
  wire logic [7:0] wr_data = i_wr_word[DATA_HI:0];
  wire logic [3:0] wr_slot = gain_slot(wr_idx);

  // ==========================================================
  // registers
  logic [NUM_CHANNELS-1:0][GAIN_W-1:0] gain_reg;
  logic [7:0] silence_low_reg;
  logic [7:0] silence_high_reg;
  logic [7:0] disable_low_reg;
  logic [7:0] disable_high_reg;
  logic [7:0] format_filter_reg;
  logic [7:0] phase_emph_reg;
  logic [7:0] oversample_reg;
  logic [7:0] step_mode_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_reg <= {NUM_CHANNELS{GAIN_RESET}};
    end else if (wr_ok && wr_slot[3]) begin
      gain_reg[wr_slot[2:0]] <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      silence_low_reg <= SILENCE_RESET;
      silence_high_reg <= SILENCE_RESET;
    end else if (wr_ok && wr_idx == IDX_SILENCE_LOW) begin
      silence_low_reg <= wr_data;
    end else if (wr_ok && wr_idx == IDX_SILENCE_HIGH) begin
      silence_high_reg <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      disable_low_reg <= DISABLE_RESET;
      disable_high_reg <= DISABLE_RESET;
    end else if (wr_ok && wr_idx == IDX_DISABLE_LOW) begin
      disable_low_reg <= wr_data;
    end else if (wr_ok && wr_idx == IDX_DISABLE_HIGH) begin
      disable_high_reg <= wr_data;
    end
  end

  // reserved test bits are stored and read back but steer nothing
  // test bits left unused
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      format_filter_reg <= FORMAT_FILTER_RESET;
      phase_emph_reg <= PHASE_EMPH_RESET;
      oversample_reg <= OVERSAMPLE_RESET;
      step_mode_reg <= STEP_MODE_RESET;
    end else if (wr_ok) begin
      case (wr_idx)
        IDX_FORMAT_FILTER: format_filter_reg <= wr_data;
        IDX_PHASE_EMPH: phase_emph_reg <= wr_data;
        IDX_OVERSAMPLE: oversample_reg <= wr_data;
        IDX_STEP_MODE: step_mode_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read back
  logic [7:0] rd_data;

  always_comb begin
    logic [3:0] slot;
    slot = gain_slot(i_rd_index);
    if (slot[3]) begin
      rd_data = gain_reg[slot[2:0]];
    end else begin
      case (i_rd_index)
        IDX_SILENCE_LOW: rd_data = silence_low_reg;
        IDX_SILENCE_HIGH: rd_data = silence_high_reg;
        IDX_DISABLE_LOW: rd_data = disable_low_reg;
        IDX_DISABLE_HIGH: rd_data = disable_high_reg;
        IDX_FORMAT_FILTER: rd_data = format_filter_reg;
        IDX_PHASE_EMPH: rd_data = phase_emph_reg;
        IDX_OVERSAMPLE: rd_data = oversample_reg;
        IDX_STEP_MODE: rd_data = step_mode_reg;
        IDX_ZERO_STATUS: rd_data = i_zero_flags;
        default: rd_data = 8'h00;
      endcase
    end
  end

  // answer carries zero msb and index
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_word <= '0;
    end else begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req) begin
        o_rd_word <= {WORD_MSB_VALUE, i_rd_index, rd_data};
      end
    end
  end

  // ==========================================================
  // attenuator
  logic step_mode_wide;
  logic [7:0] floor_now;
  logic step_pulse;
  logic [NUM_CHANNELS-1:0] chan_soft_silence;
  logic [NUM_CHANNELS-1:0][GAIN_W-1:0] target;
  logic [NUM_CHANNELS-1:0][GAIN_W-1:0] level;

  assign step_mode_wide = step_mode_reg[STEP_SEL_BIT];
  assign floor_now = silence_floor(step_mode_wide);
  assign chan_soft_silence = {silence_high_reg[HIGH_CHANNELS-1:0],
                              silence_low_reg[LOW_CHANNELS-1:0]};

  // one timer shared by all channels
  step_interval_timer #(.INTERVAL(STEP_INTERVAL_SAMPLES)) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_sample_tick(i_sample_tick),
    .o_step(step_pulse)
  );

  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    assign target[c] = ramp_target(gain_reg[c], chan_soft_silence[c],
                                   step_mode_wide);
    atten_ramp u_ramp (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_step(step_pulse),
      .i_target(target[c]),
      .o_level(level[c])
    );
  end

  assign o_applied_codes = level;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan_muted <= '0;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        o_chan_muted[c] <= (level[c] <= floor_now);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan_output_disable <= '0;
    end else begin
      o_chan_output_disable <= {disable_high_reg[HIGH_CHANNELS-1:0],
                                disable_low_reg[LOW_CHANNELS-1:0]};
    end
  end

  // ==========================================================
  // mode control outputs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gain_step_select <= 1'b0;
      o_audio_format_select <= 3'h0;
      o_rolloff_select <= 1'b0;
      o_soft_restart <= 1'b0;
      o_zero_flag_polarity <= 1'b0;
      o_output_phase_invert <= 1'b0;
      o_emphasis_rate_select <= 2'h0;
      o_emphasis_all_enable <= 1'b0;
      o_oversample_high <= 1'b0;
      o_zero_flag_combo_select <= 2'h0;
    end else begin
      o_gain_step_select <= step_mode_wide;
      o_audio_format_select <= format_filter_reg[FORMAT_LO+:3];
      o_rolloff_select <= format_filter_reg[ROLLOFF_BIT];
      o_soft_restart <= phase_emph_reg[RESTART_BIT];
      o_zero_flag_polarity <= phase_emph_reg[ZERO_POL_BIT];
      o_output_phase_invert <= phase_emph_reg[PHASE_INV_BIT];
      o_emphasis_rate_select <= phase_emph_reg[EMPH_RATE_LO+:2];
      o_emphasis_all_enable <= phase_emph_reg[EMPH_ALL_BIT];
      o_oversample_high <= oversample_reg[OVERSAMPLE_BIT];
      o_zero_flag_combo_select <= step_mode_reg[COMBO_LO+:2];
    end
  end

  // ==========================================================
  // checks
  msb_void_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr_valid && i_wr_word[WORD_MSB] |=> $stable(gain_reg) &&
      $stable(silence_low_reg) && $stable(step_mode_reg))
    else $error("write with msb set changed a register");
  gain_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rst) |-> gain_reg == {NUM_CHANNELS{GAIN_RESET}} &&
      level == {NUM_CHANNELS{GAIN_RESET}})
    else $error("gain codes not at full level after reset");
  chan7_map_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ok && wr_idx == IDX_CHAN7_GAIN |=> gain_reg[6] == $past(wr_data))
    else $error("index 16 did not load channel 7");
  chan_isolation_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ok && wr_idx == IDX_CHAN1_GAIN |=>
      gain_reg[NUM_CHANNELS-1:1] == $past(gain_reg[NUM_CHANNELS-1:1]))
    else $error("channel 1 write disturbed another channel");
  silence_down_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    step_pulse && chan_soft_silence[0] && level[0] > floor_now |=>
      level[0] == $past(level[0]) - 8'h01)
    else $error("silenced channel did not step down");
  code_kept_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ok && (wr_idx == IDX_SILENCE_LOW || wr_idx == IDX_SILENCE_HIGH)
      |=> $stable(gain_reg))
    else $error("silence write changed a gain code");
  muted_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    step_mode_wide && $stable(step_mode_wide) |=>
      o_chan_muted[0] == ($past(level[0]) <= SILENCE_FLOOR_WIDE))
    else $error("silence flag wrong in wide mode");
  disable_path_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ok && wr_idx == IDX_DISABLE_HIGH |=> ##1
      o_chan_output_disable[NUM_CHANNELS-1:LOW_CHANNELS] ==
      $past(wr_data[1:0], 2))
    else $error("output disable for channels 7-8 not applied");
  read_answer_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_rd_req |=> o_rd_valid && o_rd_word[WORD_MSB] == WORD_MSB_VALUE &&
      o_rd_word[IDX_HI:IDX_LO] == $past(i_rd_index))
    else $error("read answer malformed");
  silence_reached_c: cover property (
    @(posedge i_ref_clk) disable iff (i_rst)
    chan_soft_silence[0] ##1 level[0] == floor_now);
  release_reached_c: cover property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $fell(chan_soft_silence[0]) ##[1:1000] level[0] == gain_reg[0]);
  wide_mode_c: cover property (
    @(posedge i_ref_clk) disable iff (i_rst)
    step_mode_wide && o_chan_muted[7]);

endmodule

// ---- sim/host_port_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// host side of the control word port
module host_port_model
  import atten_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // answer from the block
  input wire logic i_rd_valid,
  input wire logic [WORD_W-1:0] i_rd_word,
  // requests to the block
  output logic o_wr_valid,
  output logic [WORD_W-1:0] o_wr_word,
  output logic o_rd_req,
  output logic [6:0] o_rd_index
);
  initial begin
    o_wr_valid = 1'b0;
    o_wr_word = '0;
    o_rd_req = 1'b0;
    o_rd_index = '0;
  end

  // ========================================================
  // one word per request, fields invert once released
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] data,
                           input logic top = 1'b0);
    @(posedge i_ref_clk);
    #1;
    o_wr_word = {top, idx, data};
    o_wr_valid = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_wr_valid = 1'b0;
    // stale word must not look like a valid one
    o_wr_word = ~o_wr_word;
  endtask

  task automatic read_reg(input logic [6:0] idx, output logic valid,
                          output logic [WORD_W-1:0] word);
    @(posedge i_ref_clk);
    #1;
    o_rd_index = idx;
    o_rd_req = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_rd_req = 1'b0;
    o_rd_index = ~o_rd_index;
    // answer is registered, so it stands one cycle after the request
    valid = i_rd_valid;
    word = i_rd_word;
  endtask
endmodule

// ---- sim/dac_mode_regs_attenuator_test.sv ----
`timescale 1ns/1ps
module dac_mode_regs_attenuator_test;
  import atten_pkg::*;
  logic i_ref_clk, i_rst, wr_valid, rd_req, rd_valid, tick;
  logic [15:0] wr_word, rd_word;
  logic [6:0] rd_index;
  logic [7:0] zero_flags, muted, out_dis;
  logic [63:0] applied;
  logic step_sel, rolloff, restart, zpol, pinv, eall, over;
  logic [2:0] afmt;
  logic [1:0] erate, combo;
  logic [7:0] shadow [0:31];
  logic [7:0] lvl [0:7];
  int err_total, tests_run, ticks;

  dac_mode_regs_attenuator dac_mode_regs_attenuator_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_wr_valid(wr_valid), .i_wr_word(wr_word),
    .i_rd_req(rd_req), .i_rd_index(rd_index),
    .o_rd_valid(rd_valid), .o_rd_word(rd_word),
    .i_sample_tick(tick), .i_zero_flags(zero_flags),
    .o_applied_codes(applied), .o_chan_muted(muted),
    .o_chan_output_disable(out_dis), .o_gain_step_select(step_sel),
    .o_audio_format_select(afmt), .o_rolloff_select(rolloff),
    .o_soft_restart(restart), .o_zero_flag_polarity(zpol),
    .o_output_phase_invert(pinv), .o_emphasis_rate_select(erate),
    .o_emphasis_all_enable(eall), .o_oversample_high(over),
    .o_zero_flag_combo_select(combo)
  );

  host_port_model host_port_model_inst (
    .i_ref_clk(i_ref_clk), .i_rd_valid(rd_valid), .i_rd_word(rd_word),
    .o_wr_valid(wr_valid), .o_wr_word(wr_word),
    .o_rd_req(rd_req), .o_rd_index(rd_index)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // ==========================================================
  // shared helpers
  task automatic check(input logic [63:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [6:0] gidx(int c);
    return (c < 6) ? 7'(c + 1) : 7'(c + 10);
  endfunction

  function automatic bit writable(logic [6:0] i);
    return (i >= 1 && i <= 10) || i == 12 || i == 13 || (i >= 16 && i <= 19);
  endfunction

  task automatic wreg(input logic [6:0] idx, input logic [7:0] data);
    host_port_model_inst.write_reg(idx, data);
    if (writable(idx)) shadow[idx] = data;
  endtask

  task automatic rd_all;
    logic v;
    logic [15:0] w;
    for (int i = 0; i <= 20; i++) begin
      host_port_model_inst.read_reg(7'(i), v, w);
      check({v, w}, {1'b1, 1'b0, 7'(i), shadow[i]}, "register");
    end
  endtask

  // reference ramp: one step per eight ticks toward the target
  task automatic tick_n(int n);
    logic [7:0] fl, tgt, g, m;
    logic s;
    logic [63:0] e;
    repeat (n) begin
      @(posedge i_ref_clk);
      #1 tick = 1'b1;
      @(posedge i_ref_clk);
      #1 tick = 1'b0;
      ticks++;
      repeat (3) @(posedge i_ref_clk);
      #1;
      if (ticks % 8 == 0) begin
        fl = shadow[13][7] ? SILENCE_FLOOR_WIDE : SILENCE_FLOOR_FINE;
        for (int c = 0; c < 8; c++) begin
          g = shadow[gidx(c)];
          s = (c < 6) ? shadow[7][c] : shadow[18][c-6];
          tgt = (s || g <= fl) ? fl : g;
          if (lvl[c] > tgt) lvl[c]--;
          else if (lvl[c] < tgt) lvl[c]++;
          e[8*c +: 8] = lvl[c];
          m[c] = (lvl[c] <= fl);
        end
        check(applied, e, "applied codes");
        check(64'(muted), 64'(m), "muted");
      end
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic s_reset;
    check(applied, {8{GAIN_RESET}}, "reset codes");
    rd_all();
  endtask

  task automatic s_regs;
    wreg(7'h08, 8'h2a);
    wreg(7'h13, 8'h01);
    wreg(7'h09, 8'h25);
    wreg(7'h0a, 8'hf9);
    wreg(7'h0c, 8'h80);
    wreg(7'h0d, 8'h60);
    wreg(7'h0e, 8'h33);
    wreg(7'h0b, 8'h44);
    wreg(7'h14, 8'h55);
    host_port_model_inst.write_reg(7'h01, 8'h10, 1'b1);
    rd_all();
    check({out_dis, afmt, rolloff, restart, zpol, pinv, erate, eall, over,
           combo, step_sel}, {8'h6a, 3'b101, 4'hf, 2'b11, 2'b11, 2'b11,
           1'b0}, "mode outputs");
    wreg(7'h0a, 8'h00);
  endtask

  task automatic s_ramp;
    wreg(7'h01, 8'hfd);
    wreg(7'h10, 8'hfe);
    wreg(7'h11, 8'hfe);
    tick_n(16);
    rd_all();
  endtask

  task automatic s_silence;
    wreg(7'h07, 8'h01);
    tick_n(8 * 130);
    wreg(7'h07, 8'h00);
    tick_n(80);
    // new code while still rising from silence
    wreg(7'h01, 8'h85);
    tick_n(80);
    rd_all();
  endtask

  task automatic s_wide;
    wreg(7'h0d, 8'h80);
    wreg(7'h12, 8'h02);
    wreg(7'h02, 8'h90);
    tick_n(8 * 110);
    check(step_sel, 1'b1, "step select");
    rd_all();
  endtask

  // ==========================================================
  // run control
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    err_total++;
    stop_test();
  end

  initial begin
    i_rst = 1'b1;
    tick = 1'b0;
    zero_flags = 8'h5a;
    err_total = 0;
    tests_run = 0;
    ticks = 0;
    for (int i = 0; i < 32; i++) shadow[i] = 8'h00;
    for (int c = 0; c < 8; c++) begin
      shadow[gidx(c)] = GAIN_RESET;
      lvl[c] = GAIN_RESET;
    end
    shadow[9] = FORMAT_FILTER_RESET;
    shadow[14] = 8'h5a;
    repeat (6) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    s_reset();
    s_regs();
    s_ramp();
    s_silence();
    s_wide();
    stop_test();
  end
endmodule
